// >>> design/lftmc_top.sv
// Tag memory controller: downlink decoder, block memory, mode shadow and uplink modulator.
// Notes on behaviour
// - Extended mode bit period is any even divisor of the field clock, 2 to 128.
// - Basic mode offers only divisors 8, 16, 32, 40, 50, 64, 100, 128.
// - Field gaps are detected and gap intervals checked before a command is used.
// - Mode register is loaded from block 0 after reset and while reading.
// - Option register is loaded from page 1 block 3 after reset and while reading.
// - Mode register refreshes during reading, reloads on reset or reset command, readable.
// - Decoder flags protocol errors; controller guards every memory access.
// - Uplink data is encoded as Manchester, bi-phase, FSK, PSK or NRZ.
// - Memory holds eleven blocks of 33 bits, each with one lock bit.
// - One write command programs all 33 bits of a block together.
// - Page 0 addresses eight blocks, page 1 addresses four.
// - Configuration block is never sent in regular reading.
// - Address 0 always selects page 0 block 0 whatever the page.
// - Page 0 block 7 holds user data or a password.
// - Option block, page 1 block 3, is never sent in regular reading.
// - Bit 0 of each block is its lock bit.
// - A locked block, lock bit included, cannot be reprogrammed over the field.
// - Opcode 11 makes the device send page 1 blocks 1 and 2 with configured modulation.
// - Logic is held in reset until the supply is good.
// - All logic runs on the clock extracted from the field.
// - Uplink switches a load across the coil following the encoded stream.
`timescale 1ns/1ps
`default_nettype none

module lftmc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             flush,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("lftmc_fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } lftmc_fifo_s;

  lftmc_fifo_s s_q, s_d;
  logic        push, pop;

  assign in_ready  = (s_q.cnt != DEPTH[AW:0]);
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (flush) begin
      s_d.wr  = '0;
      s_d.rd  = '0;
      s_d.cnt = '0;
    end else begin
      if (push) begin
        s_d.mem[s_q.wr] = in_data;
        s_d.wr          = s_q.wr + 1'b1;
      end
      if (pop) begin
        s_d.rd = s_q.rd + 1'b1;
      end
      s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : lftmc_fifo

module lftmc_top
  import lftmc_pkg::*;
#(
  parameter logic [NBLK-1:0][BLK_W-1:0] MEM_INIT = '0,
  parameter int                         PROG_FC  = 256
) (
  // Field clock and power-on reset.
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  // Analog front end.
  input  wire logic                      gap_det,
  output logic                           load_on,
  // Shadow registers and status.
  output logic [lftmc_pkg::BLK_W-1:0]    mode_reg,
  output logic [lftmc_pkg::BLK_W-1:0]    option_reg,
  output lftmc_pkg::lftmc_stat_s         status
);
  import lftmc_pkg::*;

  if (PROG_FC < 1 || PROG_FC > 65535) begin : g_bad_prog
    $error("lftmc_top PROG_FC must lie in 1..65535");
  end
  localparam logic [15:0] PROG_LAST = 16'(PROG_FC - 1);

  typedef struct packed {
    logic [NBLK-1:0][BLK_W-1:0] mem;
    logic [BLK_W-1:0]           mode;
    logic [BLK_W-1:0]           opt;
    lftmc_state_e               st;
    logic                       gap_prev;
    logic                       in_frame;
    logic                       viol;
    logic [7:0]                 on_cnt;
    logic [7:0]                 gap_cnt;
    logic [5:0]                 nbits;
    logic [CMD_LEN-1:0]         sh;
    logic [3:0]                 wr_idx;
    logic [BLK_W-1:0]           wr_data;
    logic [15:0]                pcnt;
    logic                       trace;
    logic [3:0]                 fill_idx;
    logic [6:0]                 rcnt;
    logic                       half;
    logic [DATA_W-1:0]          tx;
    logic [5:0]                 tx_left;
    logic                       tx_bit;
    logic                       tx_act;
    logic                       lvl;
    logic                       car;
    logic [2:0]                 sub;
    logic                       err;
    logic                       flush;
  } lftmc_top_s;

  lftmc_top_s       s_q, s_d;
  logic             f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [DATA_W-1:0] f_out_data;
  logic [7:0]       div;
  logic [6:0]       half_div;
  logic             half_en, bit_start;
  logic [2:0]       maxb;
  lftmc_mod_e       modsel;

  // Bit period from the shadowed configuration.
  always_comb begin
    if (s_q.mode[CFG_EXT_BIT]) begin
      div = {1'b0, s_q.mode[CFG_RATE_LSB +: CFG_RATE_W], 1'b0} + 8'h02;
    end else begin
      div = lftmc_basic_div(s_q.mode[CFG_RATE_LSB +: 3]);
    end
  end
  assign half_div  = div[7:1];
  assign half_en   = (s_q.rcnt == half_div - 7'h01);
  assign bit_start = half_en && s_q.half;
  assign maxb      = s_q.mode[CFG_MAXB_LSB +: 3];
  assign modsel    = lftmc_mod_e'(s_q.mode[CFG_MOD_LSB +: 3]);

  // Regular reading pushes data words; back-pressure holds the block index.
  assign f_in_valid  = (s_q.st == ST_READ) && !s_q.in_frame && !s_q.flush
                       && (s_q.trace || maxb != 3'h0);
  assign f_out_ready = (s_q.st == ST_READ) && bit_start && (s_q.tx_left == 6'h00);

  lftmc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (16)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .flush     (s_q.flush),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (s_q.mem[s_q.fill_idx][BLK_W-1:1]),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  always_comb begin
    logic [1:0] op;
    logic [2:0] addr;
    logic [3:0] idx;
    logic       bad_addr;
    logic       rx_bit;
    logic       rx_ok;
    op       = '0;
    addr     = '0;
    idx      = '0;
    bad_addr = 1'b0;
    rx_bit   = 1'b0;
    rx_ok    = 1'b0;
    s_d      = s_q;
    s_d.err   = 1'b0;
    s_d.flush = 1'b0;
    s_d.gap_prev = gap_det;

    // Downlink: intervals between field gaps carry the bits.
    if (s_q.st != ST_PROG) begin
      if (gap_det) begin
        s_d.on_cnt = '0;
        if (s_q.gap_cnt != 8'hff) begin
          s_d.gap_cnt = s_q.gap_cnt + 8'h01;
        end
        if (s_q.in_frame && s_q.gap_cnt > GAP_MAX_FC) begin
          s_d.viol = 1'b1;
        end
        if (!s_q.gap_prev) begin
          if (!s_q.in_frame) begin
            s_d.in_frame = 1'b1;
            s_d.nbits    = '0;
            s_d.viol     = 1'b0;
            s_d.sh       = '0;
          end else begin
            if (s_q.on_cnt >= ZERO_MIN_FC && s_q.on_cnt <= ZERO_MAX_FC) begin
              rx_ok = 1'b1;
            end else if (s_q.on_cnt >= ONE_MIN_FC && s_q.on_cnt <= ONE_MAX_FC) begin
              rx_ok  = 1'b1;
              rx_bit = 1'b1;
            end
            if (!rx_ok || s_q.nbits == CMD_LEN) begin
              s_d.viol = 1'b1;
            end else begin
              s_d.sh    = {s_q.sh[CMD_LEN-2:0], rx_bit};
              s_d.nbits = s_q.nbits + 6'h01;
            end
          end
        end
      end else begin
        s_d.gap_cnt = '0;
        if (s_q.on_cnt != 8'hff) begin
          s_d.on_cnt = s_q.on_cnt + 8'h01;
        end
        if (s_q.in_frame && s_q.on_cnt == END_FC) begin
          s_d.in_frame = 1'b0;
          s_d.flush    = 1'b1;
          s_d.tx_left  = '0;
          if (s_q.viol) begin
            s_d.err = 1'b1;
          end else if (s_q.nbits == SHORT_LEN) begin
            case (s_q.sh[1:0])
              OP_RESET: s_d.st    = ST_LOAD;
              OP_PAGE0: s_d.trace = 1'b0;
              OP_PAGE1: s_d.trace = 1'b1;
              default:  s_d.err   = 1'b1;
            endcase
            s_d.fill_idx = s_d.trace ? TRACE1_IDX : FIRST_IDX;
          end else if (s_q.nbits == CMD_LEN && s_q.sh[CMD_LEN-1]) begin
            op   = s_q.sh[CMD_LEN-1 -: 2];
            addr = s_q.sh[2:0];
            if (addr == 3'h0) begin
              idx = CFG_IDX;
            end else if (op == OP_PAGE1) begin
              bad_addr = (addr >= 3'(P1_BLKS));
              idx      = P1_BASE + {1'b0, addr};
            end else begin
              idx = {1'b0, addr};
            end
            if (bad_addr || s_q.mem[idx][LOCK_BIT]) begin
              s_d.err = 1'b1;
            end else begin
              s_d.st      = ST_PROG;
              s_d.wr_idx  = idx;
              s_d.wr_data = {s_q.sh[BLK_W+1:3], s_q.sh[BLK_W+2]};
              s_d.pcnt    = '0;
            end
          end else begin
            s_d.err = 1'b1;
          end
        end
      end
    end

    case (s_q.st)
      ST_LOAD: begin
        s_d.mode     = s_q.mem[CFG_IDX];
        s_d.opt      = s_q.mem[OPT_IDX];
        s_d.fill_idx = s_q.trace ? TRACE1_IDX : FIRST_IDX;
        s_d.flush    = 1'b1;
        s_d.tx_left  = '0;
        s_d.st       = ST_READ;
      end
      ST_READ: begin
        s_d.mode = s_q.mem[CFG_IDX];
        s_d.opt  = s_q.mem[OPT_IDX];
        if (f_in_valid && f_in_ready) begin
          if (s_q.trace) begin
            s_d.fill_idx = (s_q.fill_idx == TRACE1_IDX) ? TRACE2_IDX : TRACE1_IDX;
          end else if (s_q.fill_idx >= {1'b0, maxb}) begin
            s_d.fill_idx = FIRST_IDX;
          end else begin
            s_d.fill_idx = s_q.fill_idx + 4'h1;
          end
        end
      end
      ST_PROG: begin
        s_d.tx_act = 1'b0;
        s_d.pcnt   = s_q.pcnt + 16'h0001;
        if (s_q.pcnt == PROG_LAST) begin
          s_d.mem[s_q.wr_idx] = s_q.wr_data;
          s_d.st              = ST_LOAD;
        end
      end
      default: s_d.st = ST_LOAD;
    endcase

    // Data-rate generator: one enable per half bit.
    if (half_en) begin
      s_d.rcnt = '0;
      s_d.half = !s_q.half;
    end else begin
      s_d.rcnt = s_q.rcnt + 7'h01;
    end

    // Serializer, most significant data bit first.
    if (s_q.st == ST_READ && bit_start) begin
      if (s_q.tx_left != 6'h00) begin
        s_d.tx_bit  = s_q.tx[DATA_W-1];
        s_d.tx      = {s_q.tx[DATA_W-2:0], 1'b0};
        s_d.tx_left = s_q.tx_left - 6'h01;
        s_d.tx_act  = 1'b1;
      end else if (f_out_valid) begin
        s_d.tx_bit  = f_out_data[DATA_W-1];
        s_d.tx      = {f_out_data[DATA_W-2:0], 1'b0};
        s_d.tx_left = 6'(DATA_W - 1);
        s_d.tx_act  = 1'b1;
      end else begin
        s_d.tx_act = 1'b0;
      end
    end
    if (s_q.in_frame || s_q.flush) begin
      s_d.tx_act = 1'b0;
    end

    // Encoder state: bi-phase level, PSK phase and FSK subcarrier.
    case (modsel)
      MOD_BIPH: begin
        if (bit_start || (half_en && !s_q.half && !s_q.tx_bit)) begin
          s_d.lvl = !s_q.lvl;
        end
      end
      MOD_PSK: begin
        s_d.car = !s_q.car;
        if (bit_start && s_d.tx_bit != s_q.tx_bit) begin
          s_d.lvl = !s_q.lvl;
        end
      end
      MOD_FSK: begin
        if (s_q.sub >= (s_q.tx_bit ? FSK_ONE_HP : FSK_ZERO_HP) - 3'h1) begin
          s_d.sub = '0;
          s_d.car = !s_q.car;
        end else begin
          s_d.sub = s_q.sub + 3'h1;
        end
      end
      default: s_d.lvl = s_q.lvl;
    endcase
  end

  // Load modulation level from the encoded stream.
  always_comb begin
    logic enc;
    enc = 1'b0;
    case (modsel)
      MOD_NRZ:   enc = s_q.tx_bit;
      MOD_MANCH: enc = s_q.tx_bit ^ s_q.half;
      MOD_BIPH:  enc = s_q.lvl;
      MOD_FSK:   enc = s_q.car;
      MOD_PSK:   enc = s_q.car ^ s_q.lvl;
      default:   enc = s_q.tx_bit;
    endcase
    load_on = s_q.tx_act && enc;
  end

  // Field clock drives everything; the power-on detector holds resetn low.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q     <= '0;
      s_q.mem <= MEM_INIT;
      s_q.st  <= ST_LOAD;
    end else begin
      s_q <= s_d;
    end
  end

  assign mode_reg             = s_q.mode;
  assign option_reg           = s_q.opt;
  assign status.reading       = (s_q.st == ST_READ) && s_q.tx_act;
  assign status.trace_read    = s_q.trace;
  assign status.programming   = (s_q.st == ST_PROG);
  assign status.downlink_busy = s_q.in_frame;
  assign status.cmd_error     = s_q.err;
endmodule : lftmc_top

`default_nettype wire

// >>> common/lftmc_pkg.sv
// Shared constants, field layouts and carrier types of the tag memory controller.
package lftmc_pkg;

  // Memory organisation: eleven physical blocks of 32 data bits and one lock bit.
  localparam int BLK_W     = 33;
  localparam int DATA_W    = 32;
  localparam int NBLK      = 11;
  localparam int LOCK_BIT  = 0;
  localparam int P0_BLKS   = 8;
  localparam int P1_BLKS   = 4;

  // Physical indices; page 1 block b (1 to 3) sits at index P1_BASE + b, and address 0 maps to CFG_IDX.
  localparam logic [3:0] CFG_IDX    = 4'h0;
  localparam logic [3:0] P1_BASE    = 4'h7;
  localparam logic [3:0] TRACE1_IDX = 4'h8;
  localparam logic [3:0] TRACE2_IDX = 4'h9;
  localparam logic [3:0] OPT_IDX    = 4'ha;
  localparam logic [3:0] FIRST_IDX  = 4'h1;

  // Configuration fields inside block 0 (bit positions of the 33-bit block).
  localparam int CFG_RATE_LSB = 1;
  localparam int CFG_RATE_W   = 6;
  localparam int CFG_MOD_LSB  = 7;
  localparam int CFG_MAXB_LSB = 10;
  localparam int CFG_EXT_BIT  = 13;

  // Downlink framing, all in field clock periods.
  localparam logic [7:0] ZERO_MIN_FC = 8'h10;
  localparam logic [7:0] ZERO_MAX_FC = 8'h20;
  localparam logic [7:0] ONE_MIN_FC  = 8'h28;
  localparam logic [7:0] ONE_MAX_FC  = 8'h40;
  localparam logic [7:0] END_FC      = 8'h50;
  localparam logic [7:0] GAP_MAX_FC  = 8'h40;

  // Command layout: two opcode bits, then lock, 32 data bits, 3 address bits.
  localparam logic [5:0] SHORT_LEN = 6'h02;
  localparam logic [5:0] CMD_LEN   = 6'h26;
  localparam logic [1:0] OP_RESET  = 2'h0;
  localparam logic [1:0] OP_PAGE0  = 2'h2;
  localparam logic [1:0] OP_PAGE1  = 2'h3;

  // Subcarrier half periods for frequency shift keying.
  localparam logic [2:0] FSK_ONE_HP  = 3'h3;
  localparam logic [2:0] FSK_ZERO_HP = 3'h4;

  typedef enum logic [2:0] {MOD_NRZ, MOD_MANCH, MOD_BIPH, MOD_FSK, MOD_PSK} lftmc_mod_e;
  typedef enum logic [1:0] {ST_LOAD, ST_READ, ST_PROG} lftmc_state_e;

  typedef struct packed {
    logic reading;
    logic trace_read;
    logic programming;
    logic downlink_busy;
    logic cmd_error;
  } lftmc_stat_s;

  // Fixed basic-mode divisors, selected by the low three rate bits.
  function automatic logic [7:0] lftmc_basic_div(input logic [2:0] sel);
    case (sel)
      3'h0:    lftmc_basic_div = 8'h08;
      3'h1:    lftmc_basic_div = 8'h10;
      3'h2:    lftmc_basic_div = 8'h20;
      3'h3:    lftmc_basic_div = 8'h28;
      3'h4:    lftmc_basic_div = 8'h32;
      3'h5:    lftmc_basic_div = 8'h40;
      3'h6:    lftmc_basic_div = 8'h64;
      default: lftmc_basic_div = 8'h80;
    endcase
  endfunction : lftmc_basic_div

endpackage : lftmc_pkg

// >>> tb/lftmc_top_asserts.sv
// Concurrent checks on the ports of the tag memory controller.
`timescale 1ns/1ps
`default_nettype none
module lftmc_top_asserts
  import lftmc_pkg::*;
#(
  parameter int PROG_FC = 256
) (
  // Clock and reset.
  input wire logic                   mclk,
  input wire logic                   resetn,
  // Front end.
  input wire logic                   gap_det,
  input wire logic                   load_on,
  // Shadows and status.
  input wire logic [lftmc_pkg::BLK_W-1:0] mode_reg,
  input wire logic [lftmc_pkg::BLK_W-1:0] option_reg,
  input wire lftmc_pkg::lftmc_stat_s status
);
  import lftmc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  logic [15:0] pcnt_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) pcnt_q <= '0;
    else pcnt_q <= status.programming ? pcnt_q + 16'h1 : 16'h0;
  end

  sequence s_frame_open;
    $rose(gap_det) && !status.programming && !status.downlink_busy;
  endsequence
  sequence s_prog_done;
    $fell(status.programming);
  endsequence

  chk_prog_len: assert property (s_prog_done |-> pcnt_q == PROG_FC)
    else $error("programming time wrong");
  chk_prog_entry: assert property ($rose(status.programming) |->
    $past(status.downlink_busy) || $past(status.downlink_busy, 2))
    else $error("programming without a frame");
  chk_err_pulse: assert property (status.cmd_error |=> !status.cmd_error)
    else $error("error flag longer than one cycle");
  chk_err_excl: assert property (!(status.cmd_error && status.programming))
    else $error("error and programming together");
  chk_busy_prog: assert property (!(status.downlink_busy && status.programming))
    else $error("frame taken while programming");
  chk_frame_open: assert property (s_frame_open |-> ##[1:2] status.downlink_busy)
    else $error("gap did not open a frame");
  chk_frame_mute: assert property (status.downlink_busy [*4] |-> !status.reading)
    else $error("uplink during a frame");
  chk_load_idle: assert property (!status.reading |-> !load_on)
    else $error("load on while not reading");
  chk_mode_hold: assert property ($changed(mode_reg) |-> $past(status.programming) ||
    $past(status.programming, 2) || $past(status.programming, 3) || !$past(resetn, 2))
    else $error("mode register changed without a write");
  chk_opt_hold: assert property ($changed(option_reg) |-> $past(status.programming) ||
    $past(status.programming, 2) || $past(status.programming, 3) || !$past(resetn, 2))
    else $error("option register changed without a write");
endmodule : lftmc_top_asserts

bind lftmc_top lftmc_top_asserts #(.PROG_FC(PROG_FC)) i_chk (.mclk(mclk), .resetn(resetn),
  .gap_det(gap_det), .load_on(load_on), .mode_reg(mode_reg), .option_reg(option_reg), .status(status));
`default_nettype wire

// >>> tb/lftmc_reader.sv
// Reader model that keys field gaps onto the downlink.
`timescale 1ns/1ps
`default_nettype none
module lftmc_reader (
  // Field clock.
  input  wire logic mclk,
  // Gap detector level.
  output logic      gap_det
);
  initial gap_det = 1'b0;
  // Gaps of 8 cycles; the next gap's own wait adds one cycle, so a 0 is 25 cycles of field,
  // a 1 is 53 and 36 fits neither.
  task automatic send(input int len, input logic [37:0] v, input int bad);
    for (int i = len; i >= 0; i--) begin
      @(negedge mclk) gap_det = 1'b1;
      repeat (8) @(negedge mclk);
      gap_det = 1'b0;
      if (i > 0) repeat ((len - i == bad) ? 35 : (v[i-1] ? 52 : 24)) @(negedge mclk);
    end
    repeat (100) @(negedge mclk);
  endtask : send
endmodule : lftmc_reader
`default_nettype wire

// >>> tb/tb_lftmc_top.sv
// Self-checking bench of the tag memory controller.
`timescale 1ns/1ps
`default_nettype none
module tb_lftmc_top;
  import lftmc_pkg::*;
  localparam logic [NBLK-1:0][BLK_W-1:0] MI = {33'h0_2468_acf0, 264'h0, 33'h1_5555_5555, 33'h0_0000_0400};
  logic        mclk;
  logic        resetn;
  logic        gap_det;
  logic        load_on;
  logic [32:0] mode_reg;
  logic [32:0] option_reg;
  lftmc_stat_s status;
  logic        err_seen;
  logic [32:0] keep;
  int          miscompares;
  int          comparisons;
  int          cyc;
  int          mn;
  int          bdiv [8] = '{8, 16, 32, 40, 50, 64, 100, 128};
  int          mmin [5] = '{24, 24, 12, 3, 1};

  lftmc_top #(.MEM_INIT(MI), .PROG_FC(4)) i_dut (.mclk(mclk), .resetn(resetn), .gap_det(gap_det),
    .load_on(load_on), .mode_reg(mode_reg), .option_reg(option_reg), .status(status));
  lftmc_reader i_rd (.mclk(mclk), .gap_det(gap_det));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  function automatic logic [31:0] cfg(input logic ext, input logic [2:0] md, input logic [5:0] r);
    return {19'h0, ext, 3'h1, md, r};
  endfunction : cfg

  task automatic wcfg(input logic [1:0] op, input logic lk, input logic [31:0] d, input logic [2:0] a);
    i_rd.send(38, {op, lk, d, a}, -1);
  endtask : wcfg

  // Shortest run of load_on between changes; the first changes after a frame are skipped.
  task automatic meas(output int m);
    int   n;
    int   c;
    logic p;
    m = 999;
    n = 0;
    c = 0;
    p = load_on;
    while (n < 12) begin
      @(negedge mclk);
      c++;
      if (load_on !== p) begin
        if (n > 2 && c < m) m = c;
        n++;
        c = 0;
        p = load_on;
      end
    end
  endtask : meas

  always @(posedge mclk) if (status.cmd_error === 1'b1) err_seen <= 1'b1;

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    resetn = 1'b0;
    err_seen = 1'b0;
    miscompares = 0;
    comparisons = 0;
    cyc = 0;
    repeat (20) @(negedge mclk);
    chk("status in reset", {28'h0, status}, 33'h0);
    chk("load in reset", 33'(load_on), 33'h0);
    resetn = 1'b1;
    repeat (3) @(negedge mclk);
    chk("mode after reset", mode_reg, MI[0]);
    chk("option after reset", option_reg, MI[10]);
    $display("test reset done");
    for (int s = 0; s < 8; s++) begin
      err_seen = 1'b0;
      wcfg(OP_PAGE0, 1'b0, cfg(1'b0, 3'h0, 6'(s)), 3'h0);
      chk("mode write", mode_reg, {cfg(1'b0, 3'h0, 6'(s)), 1'b0});
      chk("no error on good write", 33'(err_seen), 33'h0);
      meas(mn);
      chk("basic period", 33'(mn), 33'(bdiv[s]));
    end
    $display("test basic rates done");
    for (int k = 0; k < 3; k++) begin
      wcfg(OP_PAGE1, 1'b0, cfg(1'b1, 3'h0, k == 0 ? 6'h00 : (k == 1 ? 6'h3f : 6'h0b)), 3'h0);
      chk("page one address zero", 33'(mode_reg[13]), 33'h1);
      meas(mn);
      chk("extended period", 33'(mn), k == 0 ? 33'h2 : (k == 1 ? 33'h80 : 33'h18));
    end
    $display("test extended rates done");
    for (int m = 0; m < 5; m++) begin
      wcfg(OP_PAGE1, 1'b0, cfg(1'b1, 3'(m), 6'h0b), 3'h0);
      meas(mn);
      chk("encoding", 33'(mn), 33'(mmin[m]));
    end
    $display("test encodings done");
    wcfg(OP_PAGE1, 1'b0, 32'h0f0f0f0f, 3'h3);
    chk("option write", option_reg, 33'h0_1e1e_1e1e);
    keep = mode_reg;
    for (int e = 0; e < 4; e++) begin
      err_seen = 1'b0;
      case (e)
        0: i_rd.send(38, {OP_PAGE1, 1'b0, 32'hffffffff, 3'h4}, -1);
        1: i_rd.send(38, {OP_PAGE0, 1'b0, 32'hffffffff, 3'h0}, 5);
        2: i_rd.send(5, 38'h1f, -1);
        default: i_rd.send(38, {2'h1, 1'b0, 32'hffffffff, 3'h0}, -1);
      endcase
      chk("error flag", 33'(err_seen), 33'h1);
      chk("memory kept", mode_reg, keep);
    end
    $display("test refusals done");
    i_rd.send(2, 38'h3, -1);
    chk("trace on", 33'(status.trace_read), 33'h1);
    i_rd.send(2, 38'h2, -1);
    chk("trace off", 33'(status.trace_read), 33'h0);
    i_rd.send(2, 38'h0, -1);
    chk("reset command", mode_reg, keep);
    $display("test short commands done");
    wcfg(OP_PAGE0, 1'b1, cfg(1'b0, 3'h0, 6'h00), 3'h0);
    chk("lock set", 33'(mode_reg[LOCK_BIT]), 33'h1);
    keep = mode_reg;
    err_seen = 1'b0;
    wcfg(OP_PAGE0, 1'b0, 32'h0, 3'h0);
    chk("locked error", 33'(err_seen), 33'h1);
    chk("locked kept", mode_reg, keep);
    $display("test lock done");
    resetn = 1'b0;
    repeat (2) @(negedge mclk);
    chk("mode in second reset", mode_reg, 33'h0);
    resetn = 1'b1;
    repeat (3) @(negedge mclk);
    chk("mode after second reset", mode_reg, MI[0]);
    chk("option after second reset", option_reg, MI[10]);
    $display("test second reset done");
    test_done();
  end
endmodule : tb_lftmc_top
`default_nettype wire
